// ===== hw/pll_ctl_pkg.sv
// register map, field positions and reset values of the loop control block
// assumes one 100 MHz bus clock and word-aligned 32-bit register access
package pll_ctl_pkg;
    localparam int          ADDR_W        = 32;
    // register index; the bus byte address is four times the index
    localparam logic [31:0] IDX_CTL       = 32'h0000_0036;
    localparam logic [31:0] IDX_BW        = 32'h0000_0037;
    localparam logic [31:0] IDX_MUL_LO    = 32'h0000_0038;
    localparam logic [31:0] IDX_MUL_HI    = 32'h0000_0039;
    localparam logic [31:0] IDX_RANGE     = 32'h0000_003A;
    localparam logic [31:0] OFF_CTL       = {IDX_CTL[29:0], 2'h0};
    localparam logic [31:0] OFF_BW        = {IDX_BW[29:0], 2'h0};
    localparam logic [31:0] OFF_MUL_LO    = {IDX_MUL_LO[29:0], 2'h0};
    localparam logic [31:0] OFF_MUL_HI    = {IDX_MUL_HI[29:0], 2'h0};
    localparam logic [31:0] OFF_RANGE     = {IDX_RANGE[29:0], 2'h0};

    localparam int          CTL_IE_BIT    = 7;
    localparam int          CTL_FLAG_BIT  = 6;
    localparam int          CTL_RUN_BIT   = 5;
    localparam int          CTL_BS_BIT    = 4;
    localparam int          BW_AUTO_BIT   = 7;
    localparam int          BW_LOCK_BIT   = 6;
    localparam int          BW_CAP_BIT    = 5;

    localparam int          MUL_HI_W      = 4;
    localparam int          MUL_LO_W      = 8;
    localparam int          MUL_W         = 12;
    localparam int          RANGE_W       = 8;

    localparam logic        RST_RUN       = 1'b1;
    localparam logic        RST_AUTO      = 1'b0;
    localparam logic        RST_CAP       = 1'b0;
    localparam logic [7:0]  RST_MUL_LO    = 8'h40;
    localparam logic [3:0]  RST_MUL_HI    = 4'h0;
    localparam logic [7:0]  RST_RANGE     = 8'h40;
    localparam logic [11:0] RST_MUL_OUT   = 12'h040;
    localparam logic [11:0] MUL_ZERO_SUB  = 12'h001;

    typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD} bus_state_type;
endpackage

// ===== hw/bit_sync.sv
// two-flop synchroniser for a group of independent status levels
// assumes each bit is a slow level, so no bus coherence is needed
module bit_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ===== hw/pll_bandwidth_divider_control.sv
// register-level control of the clock generator loop, reached over AHB-Lite
// assumes the analog loop, oscillator and clock switch sit outside on the gate outputs
module pll_bandwidth_divider_control (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        lock_detect_in,
    input  wire logic        tracking_in,
    input  wire logic        stop_mode,
    input  wire logic        osc_keep_in_stop,
    input  wire logic        break_state,
    input  wire logic        break_clear_enable,
    output logic             loop_enable_out,
    output logic             base_source_select,
    output logic             osc_enable_out,
    output logic             crystal_clock_gate,
    output logic             base_clock_gate,
    output logic             clockgen_irq,
    output logic      [11:0] multiplier_out,
    output logic      [7:0]  range_value_bits,
    output logic             capture_mode_n,
    output logic             auto_bandwidth_out
);
    pll_ctl_pkg::bus_state_type state_r;
    logic [31:0] addr_r;
    logic [7:0]  rd_byte;
    logic [7:0]  wdat;
    logic        accept;
    logic        wr_en, rd_en;
    logic        wr_ctl, wr_bw, wr_lo, wr_hi, wr_rng;
    logic        rd_ctl, rd_bw;
    logic        ie_r, flag_r, run_r, bs_r;
    logic        auto_r, man_cap_r, lock_prev_r;
    logic [7:0]  mul_lo_r;
    logic [3:0]  mul_hi_r;
    logic [7:0]  range_r;
    logic [1:0]  stat_sync;
    logic        lock_sync, trk_sync, lock_chg;
    logic        cap_vis, flag_clr_ok, stop_cut;
    logic [11:0] mul_raw;

    function automatic logic reg_hit(input logic [31:0] a, input logic [31:0] off);
        reg_hit = (a == off);
    endfunction

    bit_sync #(
        .W        (2)
    ) u_sync (
        .clk      (hclk),
        .rst_n    (hresetn),
        .async_in ({lock_detect_in, tracking_in}),
        .sync_out (stat_sync)
    );

    assign lock_sync = stat_sync[1];
    assign trk_sync  = stat_sync[0];

    // bus slave: writes take no wait state, reads take one
    assign accept = hsel && hready && htrans[1];
    assign wr_en  = (state_r == pll_ctl_pkg::ST_WR);
    assign rd_en  = (state_r == pll_ctl_pkg::ST_RD);
    assign wdat   = hwdata[7:0];
    assign wr_ctl = wr_en && reg_hit(addr_r, pll_ctl_pkg::OFF_CTL);
    assign wr_bw  = wr_en && reg_hit(addr_r, pll_ctl_pkg::OFF_BW);
    assign wr_lo  = wr_en && reg_hit(addr_r, pll_ctl_pkg::OFF_MUL_LO);
    assign wr_hi  = wr_en && reg_hit(addr_r, pll_ctl_pkg::OFF_MUL_HI);
    assign wr_rng = wr_en && reg_hit(addr_r, pll_ctl_pkg::OFF_RANGE);
    assign rd_ctl = rd_en && reg_hit(addr_r, pll_ctl_pkg::OFF_CTL);
    assign rd_bw  = rd_en && reg_hit(addr_r, pll_ctl_pkg::OFF_BW);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r   <= pll_ctl_pkg::ST_IDLE;
            addr_r    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
        end else begin
            case (state_r)
                pll_ctl_pkg::ST_IDLE, pll_ctl_pkg::ST_WR: begin
                    if (accept) begin
                        addr_r    <= haddr;
                        hreadyout <= hwrite;
                        state_r   <= hwrite ? pll_ctl_pkg::ST_WR : pll_ctl_pkg::ST_RD;
                    end else begin
                        state_r   <= pll_ctl_pkg::ST_IDLE;
                    end
                end
                pll_ctl_pkg::ST_RD: begin
                    hrdata    <= {24'h00_0000, rd_byte};
                    hreadyout <= 1'b1;
                    state_r   <= pll_ctl_pkg::ST_IDLE;
                end
                default: begin
                    hreadyout <= 1'b1;
                    state_r   <= pll_ctl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // capture mode shows status in automatic mode, hidden value otherwise
    assign cap_vis = auto_r ? trk_sync : man_cap_r;

    always_comb begin
        rd_byte = 8'h00;
        if (reg_hit(addr_r, pll_ctl_pkg::OFF_CTL)) begin
            rd_byte[pll_ctl_pkg::CTL_IE_BIT]   = ie_r;
            // flag reads zero in manual mode
            rd_byte[pll_ctl_pkg::CTL_FLAG_BIT] = flag_r && auto_r;
            rd_byte[pll_ctl_pkg::CTL_RUN_BIT]  = run_r;
            rd_byte[pll_ctl_pkg::CTL_BS_BIT]   = bs_r;
        end else if (reg_hit(addr_r, pll_ctl_pkg::OFF_BW)) begin
            rd_byte[pll_ctl_pkg::BW_AUTO_BIT]  = auto_r;
            // settled flag only in automatic mode
            rd_byte[pll_ctl_pkg::BW_LOCK_BIT]  = lock_sync && auto_r;
            rd_byte[pll_ctl_pkg::BW_CAP_BIT]   = cap_vis;
        end else if (reg_hit(addr_r, pll_ctl_pkg::OFF_MUL_HI)) begin
            rd_byte = {4'h0, mul_hi_r};
        end else if (reg_hit(addr_r, pll_ctl_pkg::OFF_MUL_LO)) begin
            rd_byte = mul_lo_r;
        end else if (reg_hit(addr_r, pll_ctl_pkg::OFF_RANGE)) begin
            rd_byte = range_r;
        end
    end

    // bandwidth mode select; settled position is never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_r <= pll_ctl_pkg::RST_AUTO;
        end else if (wr_bw) begin
            auto_r <= wdat[pll_ctl_pkg::BW_AUTO_BIT];
        end
    end

    // manual capture value kept while automatic mode runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            man_cap_r <= pll_ctl_pkg::RST_CAP;
        end else if (wr_bw && !auto_r) begin
            man_cap_r <= wdat[pll_ctl_pkg::BW_CAP_BIT];
        end
    end

    assign lock_chg = auto_r && (lock_sync != lock_prev_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_prev_r <= 1'b0;
        end else begin
            lock_prev_r <= lock_sync;
        end
    end

    // break state protects the flag unless clearing is allowed
    assign flag_clr_ok = !break_state || break_clear_enable;

    // read clears the flag; a change in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= 1'b0;
        end else if (!auto_r) begin
            flag_r <= 1'b0;
        end else if (lock_chg) begin
            flag_r <= 1'b1;
        end else if (rd_ctl && flag_clr_ok) begin
            flag_r <= 1'b0;
        end
    end

    // enable forced clear in manual mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ie_r <= 1'b0;
        end else if (!auto_r) begin
            ie_r <= 1'b0;
        end else if (wr_ctl) begin
            ie_r <= wdat[pll_ctl_pkg::CTL_IE_BIT];
        end
    end

    // run enable held while base select is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r <= pll_ctl_pkg::RST_RUN;
        end else if (wr_ctl) begin
            run_r <= wdat[pll_ctl_pkg::CTL_RUN_BIT] || bs_r
                     || (run_r && wdat[pll_ctl_pkg::CTL_BS_BIT] && range_r != 8'h00);
        end
    end

    // zero range clears and blocks base select
    // no lock check on base select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bs_r <= 1'b0;
        end else if (range_r == 8'h00) begin
            bs_r <= 1'b0;
        end else if (wr_ctl && run_r) begin
            bs_r <= wdat[pll_ctl_pkg::CTL_BS_BIT];
        end else if (wr_ctl) begin
            bs_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mul_lo_r <= pll_ctl_pkg::RST_MUL_LO;
        end else if (wr_lo && !run_r) begin
            mul_lo_r <= wdat;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mul_hi_r <= pll_ctl_pkg::RST_MUL_HI;
        end else if (wr_hi && !run_r) begin
            mul_hi_r <= wdat[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            range_r <= pll_ctl_pkg::RST_RANGE;
        end else if (wr_rng && !run_r) begin
            range_r <= wdat;
        end
    end

    assign mul_raw  = {mul_hi_r, mul_lo_r};
    // wait mode has no input here; only stop gates the outputs
    assign stop_cut = stop_mode && !osc_keep_in_stop;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            multiplier_out     <= pll_ctl_pkg::RST_MUL_OUT;
            range_value_bits   <= pll_ctl_pkg::RST_RANGE;
            capture_mode_n     <= pll_ctl_pkg::RST_CAP;
            auto_bandwidth_out <= pll_ctl_pkg::RST_AUTO;
            base_source_select <= 1'b0;
        end else begin
            multiplier_out     <= (mul_raw == 12'h000) ? pll_ctl_pkg::MUL_ZERO_SUB : mul_raw;
            range_value_bits   <= range_r;
            capture_mode_n     <= cap_vis;
            auto_bandwidth_out <= auto_r;
            base_source_select <= bs_r;
        end
    end

    // full stop cuts clocks and irq
    // oscillator kept alive, loop still stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_enable_out    <= 1'b0;
            osc_enable_out     <= 1'b1;
            crystal_clock_gate <= 1'b1;
            base_clock_gate    <= 1'b1;
            clockgen_irq       <= 1'b0;
        end else begin
            loop_enable_out    <= run_r && (range_r != 8'h00) && !stop_mode;
            osc_enable_out     <= !stop_cut;
            crystal_clock_gate <= !stop_cut;
            base_clock_gate    <= !stop_cut;
            clockgen_irq       <= flag_r && ie_r && auto_r && !stop_cut;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_read_addr;
        accept && !hwrite && (state_r != pll_ctl_pkg::ST_RD);
    endsequence
    sequence s_read_done;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_guarded_read;
        rd_ctl && auto_r && !lock_chg && break_state && !break_clear_enable;
    endsequence
    sequence s_open_read;
        rd_ctl && auto_r && !lock_chg && flag_clr_ok;
    endsequence

    a_read_wait_state: assert property (s_read_addr |=> s_read_done)
        else $error("read did not take exactly one wait state");
    a_flag_on_change: assert property (lock_chg |=> flag_r)
        else $error("settled change did not set the flag");
    a_irq_needs_enable: assert property (
        clockgen_irq |-> $past(flag_r) && $past(ie_r) && $past(auto_r))
        else $error("irq raised without flag and enable");
    a_manual_no_irq: assert property (!auto_r |=> !clockgen_irq && !flag_r)
        else $error("irq or flag live in manual mode");
    a_break_keeps_flag: assert property (s_guarded_read |=> flag_r == $past(flag_r))
        else $error("flag changed by read in protected break");
    a_read_clears_flag: assert property (s_open_read |=> !flag_r)
        else $error("control read did not clear the flag");
    a_mul_frozen: assert property ((wr_lo || wr_hi) && run_r |=> $stable(mul_raw))
        else $error("multiplier changed while running");
    a_range_frozen: assert property (wr_rng && run_r |=> $stable(range_r))
        else $error("range changed while running");
    a_mul_never_zero: assert property (multiplier_out != 12'h000)
        else $error("multiplier output reached zero");
    a_base_select_guard: assert property (bs_r |-> run_r && range_r != 8'h00)
        else $error("base select set without run or range");
    a_settled_read: assert property (
        rd_bw |=> hrdata[pll_ctl_pkg::BW_LOCK_BIT] == $past(lock_sync && auto_r))
        else $error("settled flag read back wrong");
    a_capture_restore: assert property (!auto_r |=> capture_mode_n == $past(man_cap_r))
        else $error("manual capture value not restored");
    a_full_stop: assert property (
        stop_cut |=> !crystal_clock_gate && !loop_enable_out && !clockgen_irq
                     && !osc_enable_out && !base_clock_gate)
        else $error("full stop left an output running");
    a_stop_keep_osc: assert property (
        stop_mode && osc_keep_in_stop |=> osc_enable_out && !loop_enable_out)
        else $error("stop with oscillator keep handled wrong");
endmodule

// ===== dv/pll_bandwidth_divider_control_bench.sv
// self-checking bench for the loop control block: register map, protections, flag, low power
// assumes the block is the only AHB-Lite slave, so its hreadyout is fed back as hready
module pll_bandwidth_divider_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk               = 1'b0;
    logic        hresetn            = 1'b0;
    logic        hsel               = 1'b0;
    logic [31:0] haddr              = 32'h0000_0000;
    logic [1:0]  htrans             = 2'h0;
    logic        hwrite             = 1'b0;
    logic [31:0] hwdata             = 32'h0000_0000;
    logic        lock_detect_in     = 1'b0;
    logic        tracking_in        = 1'b0;
    logic        stop_mode          = 1'b0;
    logic        osc_keep_in_stop   = 1'b0;
    logic        break_state        = 1'b0;
    logic        break_clear_enable = 1'b0;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        loop_enable_out;
    logic        base_source_select;
    logic        osc_enable_out;
    logic        crystal_clock_gate;
    logic        base_clock_gate;
    logic        clockgen_irq;
    logic [11:0] multiplier_out;
    logic [7:0]  range_value_bits;
    logic        capture_mode_n;
    logic        auto_bandwidth_out;
    int          miscompares        = 0;
    int          n_checks           = 0;

    localparam logic [31:0] CTL = pll_ctl_pkg::OFF_CTL;
    localparam logic [31:0] BW  = pll_ctl_pkg::OFF_BW;
    localparam logic [31:0] MLO = pll_ctl_pkg::OFF_MUL_LO;
    localparam logic [31:0] MHI = pll_ctl_pkg::OFF_MUL_HI;
    localparam logic [31:0] RNG = pll_ctl_pkg::OFF_RANGE;

    assign hready = hreadyout;

    always #5 hclk = ~hclk;

    pll_bandwidth_divider_control uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .lock_detect_in(lock_detect_in), .tracking_in(tracking_in), .stop_mode(stop_mode),
        .osc_keep_in_stop(osc_keep_in_stop), .break_state(break_state),
        .break_clear_enable(break_clear_enable), .loop_enable_out(loop_enable_out),
        .base_source_select(base_source_select), .osc_enable_out(osc_enable_out),
        .crystal_clock_gate(crystal_clock_gate), .base_clock_gate(base_clock_gate),
        .clockgen_irq(clockgen_irq), .multiplier_out(multiplier_out),
        .range_value_bits(range_value_bits), .capture_mode_n(capture_mode_n),
        .auto_bandwidth_out(auto_bandwidth_out)
    );

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // hready is stable between edges, so looking at the falling edge gives the sampled value
    task automatic wait_ready();
        @(negedge hclk);
        while (hready !== 1'b1) @(negedge hclk);
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_ready();
        @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        wait_ready();
        @(posedge hclk);
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wait_ready();
        @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
        @(posedge hclk);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        cmp(d, exp);
    endtask

    // outputs trail their register by one clock; also covers synchroniser delay
    task automatic settle();
        repeat (6) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic t_reset();
        rd_chk(CTL, 32'h0000_0020);
        rd_chk(BW, 32'h0000_0000);
        rd_chk(MLO, 32'h0000_0040);
        rd_chk(MHI, 32'h0000_0000);
        rd_chk(RNG, 32'h0000_0040);
        rd_chk(32'h0000_0044, 32'h0000_0000);
        settle();
        cmp(32'(multiplier_out), 32'h0000_0040);
        cmp(32'(loop_enable_out), 32'h0000_0001);
        cmp(32'(hresp), 32'h0000_0000);
    endtask

    task automatic t_divider();
        bus_wr(MLO, 8'h00);
        bus_wr(RNG, 8'h11);
        rd_chk(MLO, 32'h0000_0040);
        rd_chk(RNG, 32'h0000_0040);
        bus_wr(CTL, 8'h00);
        bus_wr(MLO, 8'h00);
        bus_wr(MHI, 8'hFF);
        rd_chk(MHI, 32'h0000_000F);
        settle();
        cmp(32'(multiplier_out), 32'h0000_0F00);
        bus_wr(MHI, 8'h00);
        settle();
        cmp(32'(multiplier_out), 32'h0000_0001);
        bus_wr(RNG, 8'h00);
        bus_wr(CTL, 8'h30);
        bus_wr(CTL, 8'h30);
        rd_chk(CTL, 32'h0000_0020);
        settle();
        cmp(32'(loop_enable_out), 32'h0000_0000);
        cmp(32'(base_source_select), 32'h0000_0000);
        bus_wr(CTL, 8'h00);
        bus_wr(RNG, 8'h5A);
        rd_chk(RNG, 32'h0000_005A);
        settle();
        cmp(32'(range_value_bits), 32'h0000_005A);
    endtask

    task automatic t_base();
        bus_wr(CTL, 8'h30);
        rd_chk(CTL, 32'h0000_0020);
        bus_wr(CTL, 8'h30);
        rd_chk(CTL, 32'h0000_0030);
        bus_wr(CTL, 8'h10);
        rd_chk(CTL, 32'h0000_0030);
        settle();
        cmp(32'(base_source_select), 32'h0000_0001);
        bus_wr(CTL, 8'h00);
        rd_chk(CTL, 32'h0000_0020);
        bus_wr(CTL, 8'h20);
        rd_chk(CTL, 32'h0000_0020);
    endtask

    task automatic t_capture();
        bus_wr(BW, 8'h20);
        rd_chk(BW, 32'h0000_0020);
        bus_wr(BW, 8'hA0);
        settle();
        rd_chk(BW, 32'h0000_0080);
        cmp(32'(auto_bandwidth_out), 32'h0000_0001);
        @(posedge hclk);
        tracking_in <= 1'b1;
        settle();
        rd_chk(BW, 32'h0000_00A0);
        cmp(32'(capture_mode_n), 32'h0000_0001);
        @(posedge hclk);
        tracking_in <= 1'b0;
        bus_wr(BW, 8'h00);
        rd_chk(BW, 32'h0000_0020);
        settle();
        cmp(32'(capture_mode_n), 32'h0000_0001);
        bus_wr(BW, 8'h00);
        rd_chk(BW, 32'h0000_0000);
    endtask

    task automatic t_irq();
        @(posedge hclk);
        lock_detect_in <= 1'b1;
        settle();
        rd_chk(CTL, 32'h0000_0020);
        rd_chk(BW, 32'h0000_0000);
        @(posedge hclk);
        lock_detect_in <= 1'b0;
        settle();
        bus_wr(BW, 8'h80);
        bus_wr(CTL, 8'hA0);
        @(posedge hclk);
        lock_detect_in <= 1'b1;
        settle();
        cmp(32'(clockgen_irq), 32'h0000_0001);
        rd_chk(BW, 32'h0000_00C0);
        rd_chk(CTL, 32'h0000_00E0);
        rd_chk(CTL, 32'h0000_00A0);
        settle();
        cmp(32'(clockgen_irq), 32'h0000_0000);
        bus_wr(CTL, 8'h20);
        @(posedge hclk);
        lock_detect_in <= 1'b0;
        settle();
        cmp(32'(clockgen_irq), 32'h0000_0000);
        rd_chk(CTL, 32'h0000_0060);
    endtask

    task automatic t_break();
        @(posedge hclk);
        break_state    <= 1'b1;
        lock_detect_in <= 1'b1;
        settle();
        rd_chk(CTL, 32'h0000_0060);
        bus_wr(CTL, 8'h20);
        rd_chk(CTL, 32'h0000_0060);
        @(posedge hclk);
        break_clear_enable <= 1'b1;
        settle();
        rd_chk(CTL, 32'h0000_0060);
        rd_chk(CTL, 32'h0000_0020);
        @(posedge hclk);
        break_state        <= 1'b0;
        break_clear_enable <= 1'b0;
        settle();
        rd_chk(CTL, 32'h0000_0020);
    endtask

    task automatic t_stop();
        bus_wr(CTL, 8'hA0);
        @(posedge hclk);
        lock_detect_in <= 1'b0;
        settle();
        cmp(32'(clockgen_irq), 32'h0000_0001);
        @(posedge hclk);
        stop_mode <= 1'b1;
        settle();
        cmp(32'({osc_enable_out, crystal_clock_gate, base_clock_gate}), 32'h0000_0000);
        cmp(32'({loop_enable_out, clockgen_irq}), 32'h0000_0000);
        @(posedge hclk);
        osc_keep_in_stop <= 1'b1;
        settle();
        cmp(32'({osc_enable_out, loop_enable_out}), 32'h0000_0002);
        @(posedge hclk);
        stop_mode <= 1'b0;
        settle();
        cmp(32'(loop_enable_out), 32'h0000_0001);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_divider();
        t_base();
        t_capture();
        t_irq();
        t_break();
        t_stop();
        tally_and_finish();
    end
endmodule
